// ===== hdl/operand_decode_params.svh
// Field positions and code values for the operand field decoder
`ifndef OPERAND_DECODE_PARAMS_SVH
`define OPERAND_DECODE_PARAMS_SVH
`define MODRM_MOD_HI     7
`define MODRM_MOD_LO     6
`define MODRM_REG_HI     5
`define MODRM_REG_LO     3
`define MODRM_RM_HI      2
`define MODRM_RM_LO      0
`define SIB_SS_HI        7
`define SIB_SS_LO        6
`define SIB_INDEX_HI     5
`define SIB_INDEX_LO     3
`define SIB_BASE_HI      2
`define SIB_BASE_LO      0
`define RM_SIB_ESCAPE    3'h4
`define MOD_REGISTER     2'h3
`define SEG3_RESERVED_LO 3'h6
`define SIX_OPCODE       2'h0
`define SRC_MODRM_REG    2'h1
`define SRC_MODRM_RM     2'h2
`endif

// ===== hdl/operand_decode_pkg.sv
// Types shared by the operand field decoder
package operand_decode_pkg;
  // Register class chosen for a general register operand
  typedef enum logic [1:0]
  {
    REG_BYTE = 2'b00,
    REG_WORD = 2'b01,
    REG_DWORD = 2'b10
  } reg_width_type;
  // Segment registers, numbered as the three-bit selector encodes them
  typedef enum logic [2:0]
  {
    extra_segment       = 3'b000,
    code_segment        = 3'b001,
    stack_segment       = 3'b010,
    data_segment        = 3'b011,
    fourth_data_segment = 3'b100,
    fifth_data_segment  = 3'b101,
    seg_none            = 3'b111
  } segment_type;
endpackage

// ===== hdl/operand_field_decoder.sv
// Operand field decoder: register, segment and addressing byte decode
//
// How it works
// [RL1] No width bit: codes 000-111 pick the eight general registers by size.
// [RL2] Width bit clear: 000-011 low bytes, 100-111 high bytes of first four.
// [RL3] Width bit set in 16-bit operation picks the eight 16-bit registers.
// [RL4] Width bit set in 32-bit operation picks the eight 32-bit registers.
// [RL5] Two-bit selector: 00 extra, 01 code, 10 stack, 11 data segment.
// [RL6] Three-bit selector adds 100 fourth, 101 fifth; 110 and 111 reserved.
// [RL7] Mode comes from addressing bytes unless the opcode fixes it.
// [RL8] 32-bit addressing: index byte follows when r/m is 100 and mod not 11.
// [RL9] With index byte, address mode comes from mod, scale, index and base.
// [RL10] Middle mod r/m bits are opcode extension or register field.
// [RL11] 16-bit addressing interprets mod r/m with the 16-bit encoding.
// [RL12] 32-bit addressing interprets mod r/m with the 32-bit encoding.
// [RL13] Address components are 16 bits or 32 bits wide per address size.
// [RL14] Width bit 0 means byte operand, 1 means full-size operand.
// [RL15] Sizes default from code segment bit; each prefix inverts its size.
// [RL16] Register field comes from opcode, mod r/m reg field or r/m field.
// [RL17] Reserved three-bit segment codes raise an invalid-opcode flag.
`timescale 1ns/1ps
`include "operand_decode_params.svh"

module operand_field_decoder
  import operand_decode_pkg::*;
(
  input  wire logic          clk,           // Core clock
  input  wire logic          sys_rst,       // Synchronous reset, high
  input  wire logic          decodeValid,   // Instruction fields are valid
  input  wire logic          codeSegDefault,// Code segment default size bit
  input  wire logic          operandPrefix, // Operand size prefix seen
  input  wire logic          addressPrefix, // Address size prefix seen
  input  wire logic          widthPresent,  // Opcode carries a width bit
  input  wire logic          widthBit,      // Width bit value
  input  wire logic [1:0]    regSource,     // Where the register field sits
  input  wire logic [2:0]    opcodeReg,     // Register field inside opcode
  input  wire logic          usesModrm,     // Mode comes from addressing byte
  input  wire logic          extUsesOpcode, // Middle bits extend the opcode
  input  wire logic [7:0]    modrmByte,     // Addressing mode byte
  input  wire logic [7:0]    sibByte,       // Scale-index-base byte
  input  wire logic          segTwoBit,     // Segment field is two bits
  input  wire logic [2:0]    segField,      // Segment selector field
  output logic               operand32,     // Operation size is 32 bits
  output logic               address32,     // Address size is 32 bits
  output reg_width_type      regWidth,      // Class of selected register
  output logic [2:0]         regIndex,      // Register number in its class
  output logic               regHighByte,   // Byte is bits 15:8 of register
  output segment_type        segSelect,     // Segment register chosen
  output logic               invalidOpcode, // Reserved segment code used
  output logic               sibFollows,    // Index byte follows mod r/m
  output logic               memOperand,    // Mod r/m names memory
  output logic [2:0]         opcodeExtensionBits, // Opcode extension
  output logic [1:0]         scaleField,    // Index scale, valid with sib
  output logic [2:0]         indexField,    // Index register number
  output logic [2:0]         baseField,     // Base register number
  output logic [1:0]         modField,      // Mode bits of mod r/m
  output logic [2:0]         rmField        // r/m bits of mod r/m
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Reserved three-bit codes, shared by the segment map and the flag
  // Kept in one place so the map and the flag can never disagree
  function automatic logic seg_reserved(input logic       two,
                                        input logic [2:0] code);
    seg_reserved = !two && code >= `SEG3_RESERVED_LO;  // RL6
  endfunction

  // Middle three bits of the mod r/m byte, register or opcode extension
  function automatic logic [2:0] modrm_mid(input logic [7:0] b);
    modrm_mid = b[`MODRM_REG_HI:`MODRM_REG_LO];        // RL10
  endfunction

  // Segment decode shared by both selector widths
  function automatic segment_type seg_decode(input logic       two,
                                             input logic [2:0] code);
    logic [2:0] full;
    full = two ? {1'b0, code[1:0]} : code;
    if (seg_reserved(two, code))
      seg_decode = seg_none;                           // RL6
    else
      seg_decode = segment_type'(full);                // RL5
  endfunction

  // ****************************************************************
  // Next-value decode
  // ****************************************************************

  logic          next_operand32;
  logic          next_address32;
  reg_width_type next_regWidth;
  logic [2:0]    next_regIndex;
  logic          next_regHighByte;
  segment_type   next_segSelect;
  logic          next_invalidOpcode;
  logic          next_sibFollows;
  logic          next_memOperand;
  logic [2:0]    next_opcodeExtensionBits;
  logic [1:0]    next_scaleField;
  logic [2:0]    next_indexField;
  logic [2:0]    next_baseField;
  logic [1:0]    next_modField;
  logic [2:0]    next_rmField;

  // All decode is combinational here; outputs are registered once
  always_comb
  begin
    logic [2:0] code;
    logic [1:0] md;
    logic [2:0] rm;
    code = opcodeReg;
    md   = modrmByte[`MODRM_MOD_HI:`MODRM_MOD_LO];
    rm   = modrmByte[`MODRM_RM_HI:`MODRM_RM_LO];
    // Prefix flips the default for this instruction only
    next_operand32 = codeSegDefault ^ operandPrefix;  // RL15
    next_address32 = codeSegDefault ^ addressPrefix;  // RL15 RL13
    // Pick the field that carries the register number
    unique case (regSource)
      `SIX_OPCODE:    code = opcodeReg;                // RL16
      `SRC_MODRM_REG: code = modrm_mid(modrmByte);     // RL16
      `SRC_MODRM_RM:  code = rm;                       // RL16
      default:        code = opcodeReg;                // RL16
    endcase
    next_regIndex    = code;
    next_regHighByte = 1'b0;
    if (widthPresent && !widthBit)
    begin
      // Byte operand: high half of the first four registers for 1xx
      next_regWidth    = REG_BYTE;                     // RL14 RL2
      next_regIndex    = {1'b0, code[1:0]};            // RL2
      next_regHighByte = code[2];                      // RL2
    end
    else if (next_operand32)
      next_regWidth = REG_DWORD;                       // RL1 RL4 RL14
    else
      next_regWidth = REG_WORD;                        // RL1 RL3 RL14
    next_segSelect     = seg_decode(segTwoBit, segField);
    next_invalidOpcode = decodeValid &&
                         seg_reserved(segTwoBit, segField); // RL17
    // Opcode-fixed modes ignore the addressing byte for mode, r/m, index byte and extension; regSource may still read it
    next_modField   = usesModrm ? md : 2'h0;           // RL7
    next_rmField    = usesModrm ? rm : 3'h0;           // RL7
    next_memOperand = usesModrm && md != `MOD_REGISTER; // RL7
    // Only the 32-bit form knows the index byte escape
    next_sibFollows = usesModrm && next_address32 &&
                      rm == `RM_SIB_ESCAPE &&
                      md != `MOD_REGISTER;            // RL8 RL12 RL11
    next_opcodeExtensionBits = (usesModrm && extUsesOpcode) ?
      modrm_mid(modrmByte) : 3'h0;                    // RL10
    // Index byte fields only mean something when that byte exists
    next_scaleField = next_sibFollows ?
      sibByte[`SIB_SS_HI:`SIB_SS_LO] : 2'h0;          // RL9
    next_indexField = next_sibFollows ?
      sibByte[`SIB_INDEX_HI:`SIB_INDEX_LO] : 3'h0;    // RL9
    next_baseField  = next_sibFollows ?
      sibByte[`SIB_BASE_HI:`SIB_BASE_LO] : 3'h0;      // RL9
    // Nothing valid: keep the last answer so later stages see it steady;
    // the invalid flag is not held, it is a one-cycle pulse
    if (!decodeValid)
    begin
      next_operand32           = operand32;
      next_address32           = address32;
      next_regWidth            = regWidth;
      next_regIndex            = regIndex;
      next_regHighByte         = regHighByte;
      next_segSelect           = segSelect;
      next_sibFollows          = sibFollows;
      next_memOperand          = memOperand;
      next_opcodeExtensionBits = opcodeExtensionBits;
      next_scaleField          = scaleField;
      next_indexField          = indexField;
      next_baseField           = baseField;
      next_modField            = modField;
      next_rmField             = rmField;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************

  // Registers only; the hold on idle cycles is decided in the decode above
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      operand32           <= 1'b0;
      address32           <= 1'b0;
      regWidth            <= REG_BYTE;
      regIndex            <= 3'h0;
      regHighByte         <= 1'b0;
      segSelect           <= extra_segment;
      invalidOpcode       <= 1'b0;
      sibFollows          <= 1'b0;
      memOperand          <= 1'b0;
      opcodeExtensionBits <= 3'h0;
      scaleField          <= 2'h0;
      indexField          <= 3'h0;
      baseField           <= 3'h0;
      modField            <= 2'h0;
      rmField             <= 3'h0;
    end
    else
    begin
      invalidOpcode       <= next_invalidOpcode;       // RL17
      operand32           <= next_operand32;
      address32           <= next_address32;
      regWidth            <= next_regWidth;
      regIndex            <= next_regIndex;
      regHighByte         <= next_regHighByte;
      segSelect           <= next_segSelect;
      sibFollows          <= next_sibFollows;
      memOperand          <= next_memOperand;
      opcodeExtensionBits <= next_opcodeExtensionBits;
      scaleField          <= next_scaleField;
      indexField          <= next_indexField;
      baseField           <= next_baseField;
      modField            <= next_modField;
      rmField             <= next_rmField;
    end
  end

endmodule

// ===== tb/fetch_stage_model.sv
// Fetch stage model that presents instruction fields to the decoder
`timescale 1ns/1ps
module fetch_stage_model
(
  input  wire logic   clk,            // Clock
  output logic        decodeValid,    // Fields valid
  output logic        codeSegDefault, // Default size
  output logic        operandPrefix,  // Size prefix
  output logic        addressPrefix,  // Address prefix
  output logic        widthPresent,   // Has width bit
  output logic        widthBit,       // Width bit
  output logic [1:0]  regSource,      // Field source
  output logic [2:0]  opcodeReg,      // Opcode field
  output logic        usesModrm,      // Mode byte used
  output logic        extUsesOpcode,  // Extension bits
  output logic [7:0]  modrmByte,      // Mode byte
  output logic [7:0]  sibByte,        // Index byte
  output logic        segTwoBit,      // Short selector
  output logic [2:0]  segField        // Selector
);
  // ************************************************
  // One instruction per call
  // ************************************************
  initial
  begin
    {decodeValid, codeSegDefault, operandPrefix, addressPrefix,
      widthPresent, widthBit, regSource, opcodeReg, usesModrm,
      extUsesOpcode, modrmByte, sibByte, segTwoBit, segField} = '0;
  end
  // Bytes are inverted once taken, since fetch has already moved on
  task automatic present(input logic [4:0] mode, input logic [1:0] src,
    input logic [2:0] oreg, input logic [1:0] me, input logic [7:0] modrm,
    input logic [7:0] sib, input logic s2, input logic [2:0] seg);
    @(posedge clk);
    {codeSegDefault, operandPrefix, addressPrefix} <= mode[4:2];
    {widthPresent, widthBit} <= mode[1:0];
    {usesModrm, extUsesOpcode} <= me;
    {regSource, opcodeReg} <= {src, oreg};
    {modrmByte, sibByte, segTwoBit, segField} <= {modrm, sib, s2, seg};
    decodeValid <= 1'b1;
    @(posedge clk);
    decodeValid <= 1'b0;
    {modrmByte, sibByte, segField} <= ~{modrm, sib, seg};
  endtask
endmodule

// ===== tb/operand_field_decoder_chk.sv
// Port checker for the operand field decoder
`timescale 1ns/1ps
module operand_field_decoder_chk
  import operand_decode_pkg::*;
(
  input wire logic          clk,            // Clock
  input wire logic          sys_rst,        // Reset
  input wire logic          decodeValid,    // Fields valid
  input wire logic          codeSegDefault, // Default size
  input wire logic          operandPrefix,  // Size prefix
  input wire logic          addressPrefix,  // Address prefix
  input wire logic          widthPresent,   // Has width bit
  input wire logic          widthBit,       // Width bit
  input wire logic          usesModrm,      // Mode byte used
  input wire logic [7:0]    modrmByte,      // Mode byte
  input wire logic          segTwoBit,      // Short selector
  input wire logic [2:0]    segField,       // Selector
  input wire logic          operand32,      // Data size
  input wire logic          address32,      // Address size
  input wire reg_width_type regWidth,       // Register class
  input wire segment_type   segSelect,      // Segment chosen
  input wire logic          invalidOpcode,  // Reserved code
  input wire logic          sibFollows      // Index byte
);
  // ************************************************
  // Relations between a taken request and its answer
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_op_size: assert property (decodeValid |=> operand32 ==
    ($past(codeSegDefault) ^ $past(operandPrefix))) else $error("op size");
  a_addr_size: assert property (decodeValid |=> address32 ==
    ($past(codeSegDefault) ^ $past(addressPrefix))) else $error("ad size");
  a_sib_rule: assert property (decodeValid && usesModrm &&
    modrmByte[2:0] == 3'h4 && modrmByte[7:6] != 2'h3 |=>
    sibFollows == address32) else $error("sib missing");
  a_no_sib: assert property (decodeValid && modrmByte[2:0] != 3'h4
    |=> !sibFollows) else $error("sib stray");
  a_byte_sel: assert property (decodeValid && widthPresent &&
    !widthBit |=> regWidth == REG_BYTE) else $error("byte class");
  a_full_sel: assert property (decodeValid && widthPresent &&
    widthBit |=> regWidth == (operand32 ? REG_DWORD : REG_WORD))
    else $error("full class");
  a_bad_seg: assert property (decodeValid && !segTwoBit &&
    segField[2:1] == 2'h3 |=> invalidOpcode && segSelect == seg_none)
    else $error("reserved seg");
  a_seg_two: assert property (decodeValid && segTwoBit |=>
    segSelect == ($past(segField) & 3'h3)) else $error("short seg");
  // Idle cycles must leave the answer alone and drop the pulse
  a_hold_out: assert property (!decodeValid |=> $stable(regWidth) &&
    $stable(segSelect) && !invalidOpcode) else $error("no hold");
  c_sib: cover property (decodeValid ##1 sibFollows);
  c_bad: cover property (invalidOpcode);
  c_byte: cover property (decodeValid ##1 regWidth == REG_BYTE);
endmodule
bind operand_field_decoder operand_field_decoder_chk u_chk (.*);

// ===== tb/tb_operand_field_decoder.sv
// Self-checking bench for the operand field decoder
`timescale 1ns/1ps
module tb_operand_field_decoder;
  import operand_decode_pkg::*;
  logic clk, sys_rst, decodeValid, codeSegDefault, operandPrefix;
  logic addressPrefix, widthPresent, widthBit, usesModrm, extUsesOpcode;
  logic segTwoBit, operand32, address32, regHighByte, invalidOpcode;
  logic sibFollows, memOperand;
  logic [1:0] regSource, scaleField, modField;
  logic [2:0] opcodeReg, segField, regIndex, opcodeExtensionBits;
  logic [2:0] indexField, baseField, rmField;
  logic [7:0] modrmByte, sibByte;
  reg_width_type regWidth;
  segment_type segSelect;
  int n_fail = 0;
  int cmp_count = 0;
  operand_field_decoder u_dut (.*);
  fetch_stage_model u_fetch (.*);
  // ************************************************
  // Clock, compare and closing
  // ************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string what, input logic [2:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Every size mode against every width form and register code
  task automatic t_regs();
    logic o32;
    logic byt;
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 3; k++)
        for (int c = 0; c < 8; c++)
        begin
          o32 = m[1] ^ m[0];
          byt = (k == 1);
          u_fetch.present({m[1:0], 1'b0, k != 0, k == 2}, 2'h0, c[2:0],
            2'h0, 8'h00, 8'h00, 1'b0, 3'h0);
          #1;
          chk("operand32", {2'h0, o32}, {2'h0, operand32});
          chk("regWidth", byt ? 3'h0 : (o32 ? 3'h2 : 3'h1), regWidth);
          chk("regIndex", byt ? {1'b0, c[1:0]} : c[2:0], regIndex);
          chk("regHighByte", {2'h0, byt & c[2]}, {2'h0, regHighByte});
        end
    $display("t_regs done");
  endtask
  // Both selector widths over all eight codes, reserved ones included
  task automatic t_segs();
    logic bad;
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 8; c++)
      begin
        bad = (s == 0) && (c >= 6);
        u_fetch.present(5'h00, 2'h0, 3'h0, 2'h0, 8'h00, 8'h00, s[0], c[2:0]);
        #1;
        chk("segSelect", s ? {1'b0, c[1:0]} : (bad ? 3'h7 : c[2:0]),
          segSelect);
        chk("invalidOpcode", {2'h0, bad}, {2'h0, invalidOpcode});
      end
    $display("t_segs done");
  endtask
  // Index byte only for 32-bit addressing, r/m 100 and memory modes
  task automatic t_sib();
    logic sib;
    for (int m = 0; m < 4; m++)
      for (int d = 0; d < 4; d++)
        for (int r = 0; r < 2; r++)
        begin
          sib = (m[1] ^ m[0]) && r == 0 && d != 3;
          u_fetch.present({m[1], 1'b0, m[0], 2'h0}, 2'h0, 3'h0, 2'h2,
            {d[1:0], 3'h2, 2'h2, r[0]}, 8'hb5, 1'b0, 3'h0);
          #1;
          chk("address32", {2'h0, m[1] ^ m[0]}, {2'h0, address32});
          chk("sibFollows", {2'h0, sib}, {2'h0, sibFollows});
          chk("scaleField", sib ? 3'h2 : 3'h0, {1'b0, scaleField});
          chk("indexField", sib ? 3'h6 : 3'h0, indexField);
          chk("baseField", sib ? 3'h5 : 3'h0, baseField);
          chk("memOperand", {2'h0, d != 3}, {2'h0, memOperand});
          chk("rmField", {2'h2, r[0]}, rmField);
        end
    $display("t_sib done");
  endtask
  // Register field taken from opcode, reg field or r/m field
  task automatic t_source();
    logic [2:0] ri;
    logic [2:0] ext;
    for (int s = 0; s < 4; s++)
    begin
      // Extension bits only when the mode byte is used and marked so
      ri = (s == 1) ? 3'h3 : ((s == 2) ? 3'h6 : 3'h5);
      ext = (s == 0 || s == 2) ? 3'h3 : 3'h0;
      u_fetch.present(5'h10, s[1:0], 3'h5, {s != 3, s != 1}, 8'hde, 8'h00,
        1'b0, 3'h0);
      #1;
      chk("regIndex", ri, regIndex);
      chk("regWidth", 3'h2, regWidth);
      chk("modField", s == 3 ? 3'h0 : 3'h3, {1'b0, modField});
      chk("opcodeExtensionBits", ext, opcodeExtensionBits);
    end
    $display("t_source done");
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_segs();
    t_sib();
    t_source();
    wrap_up();
  end
endmodule
